// >>> vjsel_pkg.sv
package vjsel_pkg;
	localparam int NCH = 4;
	localparam int PROG_CYCLE_MS = 5;
	localparam int WINDOW_MS = 20;
	localparam int HIST = WINDOW_MS / PROG_CYCLE_MS;
	localparam int CLK_KHZ = 200000;
	localparam int TRIP_HOLD_MS = 20;
	localparam int TRIP_HOLD_CYC = TRIP_HOLD_MS * CLK_KHZ;
	localparam int BLOCK_LEAD_MS = 5;
	localparam int REC_DEPTH = 12;
	localparam int TS_W = 40;
	localparam int DIFF_W = 17;
	localparam int QUO_W = 23;
	localparam int REC_W = 81;
	localparam int REC_GRP_LO = 0;
	localparam int REC_ALM_LO = 3;
	localparam int REC_TRP_LO = 20;
	localparam int REC_FLT_LO = 37;
	localparam int REC_CODE_LO = 39;
	localparam int REC_TS_LO = 41;
	localparam logic [6:0] RATIO_SCALE = 7'h64;
	localparam logic [15:0] RATIO_MAX = 16'h8CA0;
	localparam int CTRL_ALM_EN = 0;
	localparam int CTRL_FORCE_EN = 1;
	localparam int CTRL_FORCE_LO = 2;
	localparam int CTRL_MASK_LO = 4;
	localparam int CTRL_ALL = 8;
	localparam int CTRL_GRP_LO = 9;
	localparam logic [11:0] CTRL_RST = 12'h070;
	localparam logic [15:0] UVLIM_RST = 16'h251C;
	localparam logic [15:0] TRIP_SET_RST = 16'h01F4;
	localparam logic [15:0] ALM_SET_RST = 16'h01F4;
	localparam logic [5:0] EVCFG_RST = 6'h3F;
	localparam int EV_BLK_ON = 0;
	localparam int EV_BLK_OFF = 1;
	localparam int EV_TRP_ON = 2;
	localparam int EV_TRP_OFF = 3;
	localparam int EV_ALM_ON = 4;
	localparam int EV_ALM_OFF = 5;
	localparam logic [1:0] REC_BLK = 2'h0;
	localparam logic [1:0] REC_TRP = 2'h1;
	localparam logic [1:0] REC_ALM = 2'h2;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_UVLIM = 8'h04;
	localparam logic [7:0] A_TRIP_SET = 8'h08;
	localparam logic [7:0] A_ALM_SET = 8'h0C;
	localparam logic [7:0] A_EVCFG = 8'h10;
	localparam logic [7:0] A_STATUS = 8'h14;
	localparam logic [7:0] A_IRQ_STAT = 8'h18;
	localparam logic [7:0] A_IRQ_MASK = 8'h1C;
	localparam logic [7:0] A_CNT_CLR = 8'h20;
	localparam logic [7:0] A_CNT_ALM = 8'h24;
	localparam logic [7:0] A_CNT_TRP = 8'h28;
	localparam logic [7:0] A_CNT_BLK = 8'h2C;
	localparam logic [3:0] A_ANG_HI = 4'h3;
	localparam logic [3:0] A_RAT_HI = 4'h4;
	localparam logic [7:0] A_REC_SEL = 8'h50;
	localparam logic [7:0] A_REC_TLO = 8'h54;
	localparam logic [7:0] A_REC_THI = 8'h58;
	localparam logic [7:0] A_REC_INFO = 8'h5C;
	localparam logic [7:0] A_REC_TRP = 8'h60;
	localparam logic [7:0] A_REC_ALM = 8'h64;
	typedef enum logic [1:0] {
		VJSEL_NORMAL = 2'b00,
		VJSEL_BLOCKED = 2'b01,
		VJSEL_TRIP = 2'b10,
		VJSEL_ALARM = 2'b11
	} vjsel_state_t;
endpackage : vjsel_pkg

// >>> vjsel_rec_mem.sv
`timescale 1ns/100ps
`default_nettype none
module vjsel_rec_mem (
	input wire logic clk_sys_in,
	input wire logic wr_en_in,
	input wire logic [3:0] wr_addr_in,
	input wire logic [vjsel_pkg::REC_W-1:0] wr_data_in,
	input wire logic [3:0] rd_addr_in,
	output logic [vjsel_pkg::REC_W-1:0] rd_data_out
);
	logic [vjsel_pkg::REC_W-1:0] mem [vjsel_pkg::REC_DEPTH];

	always_ff @(posedge clk_sys_in)
	begin
		if (wr_en_in)
		begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem[rd_addr_in];
	end
endmodule : vjsel_rec_mem
`default_nettype wire

// >>> vjsel_top.sv
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module vjsel_top #(
	parameter int TRIP_HOLD_CYC = vjsel_pkg::TRIP_HOLD_CYC
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic cycle_start_in,
	input wire logic block_in,
	input wire logic [vjsel_pkg::TS_W-1:0] ts_ms_in,
	input wire logic [vjsel_pkg::NCH-1:0][15:0] angle_in,
	input wire logic [vjsel_pkg::NCH-1:0][15:0] volt_in,
	input wire logic [vjsel_pkg::NCH-1:0] ch_avail_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	output logic [1:0] status_out,
	output logic sel_ok_out,
	output logic blocked_out,
	output logic trip_out,
	output logic alarm_out,
	output logic evt_valid_out,
	output logic [5:0] evt_mask_out,
	output logic [vjsel_pkg::TS_W-1:0] evt_time_out,
	output logic irq_out
);
	localparam int N = vjsel_pkg::NCH;
	localparam int H = vjsel_pkg::HIST;
	localparam int DW = vjsel_pkg::DIFF_W;
	localparam int QW = vjsel_pkg::QUO_W;
	localparam int RW = vjsel_pkg::REC_W;
	localparam int TW = $clog2(TRIP_HOLD_CYC + 1);

	logic [11:0] ctrl, next_ctrl;
	logic [15:0] uvlim, next_uvlim, trip_set, next_trip_set, alm_set, next_alm_set;
	logic [5:0] evcfg, next_evcfg, irq_stat, next_irq_stat, irq_mask, next_irq_mask;
	logic [3:0] rec_sel, next_rec_sel;
	logic [2:0] cnt_clr;
	logic [31:0] next_rdata;
	logic [H-1:0][N-1:0][15:0] hist, next_hist;
	logic [N-1:0][DW-1:0] diff, next_diff;
	logic blk_s, next_blk_s, eval, next_eval;
	logic busy, next_busy;
	logic [1:0] ch, next_ch;
	logic [4:0] dcnt, next_dcnt;
	logic [16:0] rem, next_rem, sh;
	logic [QW-1:0] quo, next_quo;
	logic [N-1:0][15:0] ratio, next_ratio;
	logic trip_pu_d, next_trip_pu_d, alm_pu_d, next_alm_pu_d;
	logic next_blk, next_trip, next_alm, next_sel_ok;
	logic [TW-1:0] timer, next_timer;
	vjsel_pkg::vjsel_state_t next_status;
	logic [5:0] ev;
	logic [2:0][31:0] cnt, next_cnt;
	logic [3:0] wr_ptr, next_wr_ptr, rec_cnt, next_rec_cnt, rd_idx;
	logic [4:0] t;
	logic rec_we;
	logic [1:0] code, fault;
	logic [N-1:0] fv;
	logic [RW-1:0] rec_wdata, rec_rdata;
	logic [N-1:0] ex_trip, ex_alm, uvc, mask, mon;
	logic [N-1:0][DW-1:0] adiff;
	logic trip_pu, alm_pu, uv_blk, blk_cond, rise_t, rise_a;

	assign mask = ctrl[vjsel_pkg::CTRL_MASK_LO +: N];
	assign mon = mask & ch_avail_in;

	for (genvar i = 0; i < N; i++)
	begin : g_ch
		assign adiff[i] = diff[i][DW-1] ? DW'(~diff[i] + 1'h1) : diff[i];
		assign ex_trip[i] = adiff[i] >= {1'h0, trip_set};
		assign ex_alm[i] = adiff[i] >= {1'h0, alm_set};
		assign uvc[i] = volt_in[i] < uvlim;
	end

	// Any or all of the monitored channels must pick up
	always_comb
	begin
		if (ctrl[vjsel_pkg::CTRL_ALL])
		begin
			trip_pu = (|mon) && ((ex_trip & mon) == mon);
			alm_pu = (|mon) && ((ex_alm & mon) == mon);
		end
		else
		begin
			trip_pu = |(ex_trip & mon);
			alm_pu = |(ex_alm & mon);
		end
		alm_pu = alm_pu && ctrl[vjsel_pkg::CTRL_ALM_EN];
		uv_blk = |(uvc & mon);
		blk_cond = blk_s | uv_blk;
		rise_t = eval & trip_pu & ~trip_pu_d;
		rise_a = eval & alm_pu & ~alm_pu_d;
	end

	// Measurement history, block sampling and ratio divider
	always_comb
	begin
		next_hist = hist;
		next_diff = diff;
		next_blk_s = blk_s;
		next_eval = cycle_start_in;
		next_busy = busy;
		next_ch = ch;
		next_dcnt = dcnt;
		next_rem = rem;
		next_quo = quo;
		next_ratio = ratio;
		sh = {rem[15:0], quo[QW-1]};
		if (cycle_start_in)
		begin
			next_blk_s = block_in;
			next_hist[0] = angle_in;
			for (int h = 1; h < H; h++)
			begin
				next_hist[h] = hist[h-1];
			end
			for (int i = 0; i < N; i++)
			begin
				next_diff[i] = DW'($signed(angle_in[i])) - DW'($signed(hist[H-1][i]));
			end
		end
		if (eval && !busy)
		begin
			next_busy = 1'h1;
			next_ch = 2'h0;
			next_dcnt = 5'(QW);
			next_rem = 17'h0_0000;
			next_quo = QW'(volt_in[0]) * QW'(vjsel_pkg::RATIO_SCALE);
		end
		else if (busy && dcnt == 5'h00)
		begin
			next_ratio[ch] = (quo > QW'(vjsel_pkg::RATIO_MAX)) ? vjsel_pkg::RATIO_MAX
				: quo[15:0];
			if (ch == 2'(N - 1))
			begin
				next_busy = 1'h0;
			end
			else
			begin
				next_ch = ch + 2'h1;
				next_dcnt = 5'(QW);
				next_rem = 17'h0_0000;
				next_quo = QW'(volt_in[ch + 2'h1]) * QW'(vjsel_pkg::RATIO_SCALE);
			end
		end
		else if (busy)
		begin
			next_dcnt = dcnt - 5'h01;
			if (sh >= {1'h0, uvlim})
			begin
				next_rem = sh - {1'h0, uvlim};
				next_quo = {quo[QW-2:0], 1'h1};
			end
			else
			begin
				next_rem = sh;
				next_quo = {quo[QW-2:0], 1'h0};
			end
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			hist <= '0;
			diff <= '0;
			blk_s <= 1'h0;
			eval <= 1'h0;
			busy <= 1'h0;
			ch <= 2'h0;
			dcnt <= 5'h00;
			rem <= '0;
			quo <= '0;
			ratio <= '0;
		end
		else
		begin
			hist <= next_hist;
			diff <= next_diff;
			blk_s <= next_blk_s;
			eval <= next_eval;
			busy <= next_busy;
			ch <= next_ch;
			dcnt <= next_dcnt;
			rem <= next_rem;
			quo <= next_quo;
			ratio <= next_ratio;
		end
	end

	// Protection state, events, counters and records
	always_comb
	begin
		next_trip_pu_d = eval ? trip_pu : trip_pu_d;
		next_alm_pu_d = eval ? alm_pu : alm_pu_d;
		next_trip = trip_out;
		next_timer = timer;
		if (trip_out)
		begin
			if (timer == '0)
			begin
				next_trip = 1'h0;
			end
			else
			begin
				next_timer = timer - 1'h1;
			end
		end
		if (rise_t && !blk_cond)
		begin
			next_trip = 1'h1;
			next_timer = TW'(TRIP_HOLD_CYC - 1);
		end
		next_alm = eval ? (alm_pu & (alarm_out | (rise_a & ~blk_cond))) : alarm_out;
		next_blk = eval ? (uv_blk | (blk_s & (trip_pu | alm_pu)
			& (blocked_out | rise_t | rise_a))) : blocked_out;
		next_sel_ok = (|mask) && ((mask & ~ch_avail_in) == '0);
		if (ctrl[vjsel_pkg::CTRL_FORCE_EN])
			next_status = vjsel_pkg::vjsel_state_t'(ctrl[vjsel_pkg::CTRL_FORCE_LO +: 2]);
		else if (next_blk)
			next_status = vjsel_pkg::VJSEL_BLOCKED;
		else if (next_trip)
			next_status = vjsel_pkg::VJSEL_TRIP;
		else if (next_alm)
			next_status = vjsel_pkg::VJSEL_ALARM;
		else
			next_status = vjsel_pkg::VJSEL_NORMAL;
		ev[vjsel_pkg::EV_BLK_ON] = next_blk & ~blocked_out;
		ev[vjsel_pkg::EV_BLK_OFF] = ~next_blk & blocked_out;
		ev[vjsel_pkg::EV_TRP_ON] = next_trip & ~trip_out;
		ev[vjsel_pkg::EV_TRP_OFF] = ~next_trip & trip_out;
		ev[vjsel_pkg::EV_ALM_ON] = next_alm & ~alarm_out;
		ev[vjsel_pkg::EV_ALM_OFF] = ~next_alm & alarm_out;
		for (int k = 0; k < 3; k++)
		begin
			next_cnt[k] = cnt_clr[k] ? 32'h0000_0000 : cnt[k];
			if (ev[2 * (2 - k)])
			begin
				next_cnt[k] = next_cnt[k] + 32'h0000_0001;
			end
		end
		rec_we = ev[vjsel_pkg::EV_BLK_ON] | ev[vjsel_pkg::EV_TRP_ON] | ev[vjsel_pkg::EV_ALM_ON];
		code = ev[vjsel_pkg::EV_BLK_ON] ? vjsel_pkg::REC_BLK
			: ev[vjsel_pkg::EV_TRP_ON] ? vjsel_pkg::REC_TRP : vjsel_pkg::REC_ALM;
		case (code)
			vjsel_pkg::REC_TRP: fv = ex_trip & mon;
			vjsel_pkg::REC_ALM: fv = ex_alm & mon;
			default: fv = (ex_trip | ex_alm | uvc) & mon;
		endcase
		fault = 2'h0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (fv[i])
				fault = 2'(i);
		end
		rec_wdata = {ts_ms_in, code, fault,
			(code != vjsel_pkg::REC_ALM) ? diff[fault] : {DW{1'h0}},
			(code != vjsel_pkg::REC_TRP) ? diff[fault] : {DW{1'h0}},
			ctrl[vjsel_pkg::CTRL_GRP_LO +: 3]};
		next_wr_ptr = wr_ptr;
		next_rec_cnt = rec_cnt;
		if (rec_we)
		begin
			next_wr_ptr = (wr_ptr == 4'(vjsel_pkg::REC_DEPTH - 1)) ? 4'h0 : wr_ptr + 4'h1;
			if (rec_cnt != 4'(vjsel_pkg::REC_DEPTH))
				next_rec_cnt = rec_cnt + 4'h1;
		end
		t = 5'(wr_ptr) + 5'(vjsel_pkg::REC_DEPTH - 1) - 5'(rec_sel);
		rd_idx = (t >= 5'(vjsel_pkg::REC_DEPTH)) ? 4'(t - 5'(vjsel_pkg::REC_DEPTH)) : t[3:0];
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			trip_pu_d <= 1'h0;
			alm_pu_d <= 1'h0;
			trip_out <= 1'h0;
			alarm_out <= 1'h0;
			blocked_out <= 1'h0;
			timer <= '0;
			status_out <= vjsel_pkg::VJSEL_NORMAL;
			sel_ok_out <= 1'h0;
			evt_valid_out <= 1'h0;
			evt_mask_out <= 6'h00;
			evt_time_out <= '0;
			cnt <= '0;
			wr_ptr <= 4'h0;
			rec_cnt <= 4'h0;
		end
		else
		begin
			trip_pu_d <= next_trip_pu_d;
			alm_pu_d <= next_alm_pu_d;
			trip_out <= next_trip;
			alarm_out <= next_alm;
			blocked_out <= next_blk;
			timer <= next_timer;
			status_out <= next_status;
			sel_ok_out <= next_sel_ok;
			evt_valid_out <= |(ev & evcfg);
			evt_mask_out <= ev & evcfg;
			evt_time_out <= ts_ms_in;
			cnt <= next_cnt;
			wr_ptr <= next_wr_ptr;
			rec_cnt <= next_rec_cnt;
		end
	end

	vjsel_rec_mem u_rec_mem (
		.clk_sys_in(clk_sys_in),
		.wr_en_in(rec_we),
		.wr_addr_in(wr_ptr),
		.wr_data_in(rec_wdata),
		.rd_addr_in(rd_idx),
		.rd_data_out(rec_rdata)
	);

	// Register file and read mux
	always_comb
	begin
		next_ctrl = ctrl;
		next_uvlim = uvlim;
		next_trip_set = trip_set;
		next_alm_set = alm_set;
		next_evcfg = evcfg;
		next_irq_mask = irq_mask;
		next_rec_sel = rec_sel;
		next_irq_stat = irq_stat;
		cnt_clr = 3'h0;
		next_rdata = 32'h0000_0000;
		if (reg_wr_in)
		begin
			case (reg_addr_in)
				vjsel_pkg::A_CTRL: next_ctrl = reg_wdata_in[11:0];
				vjsel_pkg::A_UVLIM: next_uvlim = reg_wdata_in[15:0];
				vjsel_pkg::A_TRIP_SET: next_trip_set = reg_wdata_in[15:0];
				vjsel_pkg::A_ALM_SET: next_alm_set = reg_wdata_in[15:0];
				vjsel_pkg::A_EVCFG: next_evcfg = reg_wdata_in[5:0];
				vjsel_pkg::A_IRQ_STAT: next_irq_stat = irq_stat & ~reg_wdata_in[5:0];
				vjsel_pkg::A_IRQ_MASK: next_irq_mask = reg_wdata_in[5:0];
				vjsel_pkg::A_CNT_CLR: cnt_clr = reg_wdata_in[2:0];
				vjsel_pkg::A_REC_SEL: next_rec_sel = reg_wdata_in[3:0];
				default: next_ctrl = ctrl;
			endcase
		end
		// Set wins over a same-cycle clear
		next_irq_stat = next_irq_stat | ev;
		if (reg_rd_in)
		begin
			case (reg_addr_in)
				vjsel_pkg::A_CTRL: next_rdata = 32'(ctrl);
				vjsel_pkg::A_UVLIM: next_rdata = 32'(uvlim);
				vjsel_pkg::A_TRIP_SET: next_rdata = 32'(trip_set);
				vjsel_pkg::A_ALM_SET: next_rdata = 32'(alm_set);
				vjsel_pkg::A_EVCFG: next_rdata = 32'(evcfg);
				vjsel_pkg::A_STATUS: next_rdata = 32'({rec_cnt, blk_s, sel_ok_out, status_out});
				vjsel_pkg::A_IRQ_STAT: next_rdata = 32'(irq_stat);
				vjsel_pkg::A_IRQ_MASK: next_rdata = 32'(irq_mask);
				vjsel_pkg::A_CNT_ALM: next_rdata = cnt[0];
				vjsel_pkg::A_CNT_TRP: next_rdata = cnt[1];
				vjsel_pkg::A_CNT_BLK: next_rdata = cnt[2];
				vjsel_pkg::A_REC_SEL: next_rdata = 32'(rec_sel);
				vjsel_pkg::A_REC_TLO: next_rdata = rec_rdata[vjsel_pkg::REC_TS_LO +: 32];
				vjsel_pkg::A_REC_THI: next_rdata = 32'(rec_rdata[RW-1 -: 8]);
				vjsel_pkg::A_REC_INFO: next_rdata = 32'({rec_rdata[vjsel_pkg::REC_GRP_LO +: 3],
					rec_rdata[vjsel_pkg::REC_FLT_LO +: 2], rec_rdata[vjsel_pkg::REC_CODE_LO +: 2]});
				vjsel_pkg::A_REC_TRP: next_rdata = 32'($signed(rec_rdata[vjsel_pkg::REC_TRP_LO +: DW]));
				vjsel_pkg::A_REC_ALM: next_rdata = 32'($signed(rec_rdata[vjsel_pkg::REC_ALM_LO +: DW]));
				default:
				begin
					if (reg_addr_in[7:4] == vjsel_pkg::A_ANG_HI)
						next_rdata = 32'($signed(diff[reg_addr_in[3:2]]));
					else if (reg_addr_in[7:4] == vjsel_pkg::A_RAT_HI)
						next_rdata = 32'(ratio[reg_addr_in[3:2]]);
				end
			endcase
			// Unwritten record slots read as zero
			if (reg_addr_in >= vjsel_pkg::A_REC_TLO && rec_sel >= rec_cnt)
				next_rdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			ctrl <= vjsel_pkg::CTRL_RST;
			uvlim <= vjsel_pkg::UVLIM_RST;
			trip_set <= vjsel_pkg::TRIP_SET_RST;
			alm_set <= vjsel_pkg::ALM_SET_RST;
			evcfg <= vjsel_pkg::EVCFG_RST;
			irq_stat <= 6'h00;
			irq_mask <= 6'h00;
			rec_sel <= 4'h0;
			reg_rdata_out <= 32'h0000_0000;
			irq_out <= 1'h0;
		end
		else
		begin
			ctrl <= next_ctrl;
			uvlim <= next_uvlim;
			trip_set <= next_trip_set;
			alm_set <= next_alm_set;
			evcfg <= next_evcfg;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			rec_sel <= next_rec_sel;
			reg_rdata_out <= next_rdata;
			irq_out <= |(next_irq_stat & next_irq_mask);
		end
	end
endmodule : vjsel_top
`default_nettype wire

// >>> vjsel_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module vjsel_assertions #(
	parameter int TRIP_HOLD_CYC = 20
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic cycle_start_in,
	input wire logic [1:0] status_out,
	input wire logic blocked_out,
	input wire logic trip_out,
	input wire logic alarm_out,
	input wire logic evt_valid_out,
	input wire logic [5:0] evt_mask_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	int trip_cnt;
	int next_trip_cnt;
	always_comb
	begin
		next_trip_cnt = (rst_in || !trip_out) ? 0 : trip_cnt + 1;
	end
	always_ff @(posedge clk_sys_in)
	begin
		trip_cnt <= next_trip_cnt;
	end
	AST_BLK_FIRST: assert property (blocked_out |-> status_out == 2'h1)
		else $error("blocked not shown first");
	AST_TRIP_NEXT: assert property (trip_out && !blocked_out |-> status_out == 2'h2)
		else $error("trip state wrong");
	AST_ALM_LAST: assert property (alarm_out && !trip_out && !blocked_out |-> status_out == 2'h3)
		else $error("alarm state wrong");
	AST_NORMAL: assert property (!(blocked_out || trip_out || alarm_out) |-> status_out == 2'h0)
		else $error("normal state wrong");
	AST_TRIP_HOLD: assert property ($fell(trip_out) |-> trip_cnt == TRIP_HOLD_CYC)
		else $error("trip hold length wrong");
	AST_TRIP_MAX: assert property (trip_out |-> trip_cnt < TRIP_HOLD_CYC)
		else $error("trip held too long");
	AST_TRIP_START: assert property ($rose(trip_out) |-> $past(cycle_start_in, 2) || $past(cycle_start_in, 3))
		else $error("trip outside program cycle");
	AST_ALM_START: assert property ($rose(alarm_out) |-> $past(cycle_start_in, 2) || $past(cycle_start_in, 3))
		else $error("alarm outside program cycle");
	AST_BLK_ONLY: assert property ($rose(blocked_out) |-> !$rose(trip_out) && !$rose(alarm_out))
		else $error("blocked pick-up went on");
	AST_EV_TON: assert property (evt_valid_out && evt_mask_out[2] |-> $rose(trip_out))
		else $error("trip on event misplaced");
	AST_EV_TOFF: assert property (evt_valid_out && evt_mask_out[3] |-> $fell(trip_out))
		else $error("trip off event misplaced");
	AST_EV_BON: assert property (evt_valid_out && evt_mask_out[0] |-> $rose(blocked_out))
		else $error("block on event misplaced");
	AST_EV_PULSE: assert property (evt_valid_out |=> !evt_valid_out)
		else $error("event pulse too long");
	cover property ($rose(trip_out));
	cover property ($rose(blocked_out));
	cover property ($rose(alarm_out));
endmodule : vjsel_assertions
bind vjsel_top vjsel_assertions #(.TRIP_HOLD_CYC(TRIP_HOLD_CYC)) u_chk (
	.clk_sys_in(clk_sys_in),
	.rst_in(rst_in),
	.cycle_start_in(cycle_start_in),
	.status_out(status_out),
	.blocked_out(blocked_out),
	.trip_out(trip_out),
	.alarm_out(alarm_out),
	.evt_valid_out(evt_valid_out),
	.evt_mask_out(evt_mask_out)
);
`default_nettype wire

// >>> vjsel_blk_matrix.sv
`timescale 1ns/100ps
`default_nettype none
module vjsel_blk_matrix (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic req_in,
	input wire logic [3:0] lag_in,
	output logic block_out
);
	logic [3:0] wait_cnt;
	logic [3:0] next_wait_cnt;
	logic next_block;
	// Level follows request after lag; callers raise it well ahead of the cycle
	always_comb
	begin
		next_wait_cnt = (req_in == block_out) ? 4'h0 : wait_cnt + 4'h1;
		next_block = (wait_cnt >= lag_in) ? req_in : block_out;
	end
	always_ff @(posedge clk_sys_in)
	begin
		wait_cnt <= rst_in ? 4'h0 : next_wait_cnt;
		block_out <= rst_in ? 1'b0 : next_block;
	end
endmodule : vjsel_blk_matrix
`default_nettype wire

// >>> vjsel_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module vjsel_top_tb;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic cycle_start_in = 1'b0;
	logic blk_req = 1'b0;
	logic block_in;
	logic [39:0] ts_ms_in = '0;
	logic [3:0][15:0] angle_in = '0;
	logic [3:0][15:0] volt_in = {4{16'h4A38}};
	logic [3:0] ch_avail_in = 4'hF;
	logic [7:0] reg_addr_in = '0;
	logic [31:0] reg_wdata_in = '0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] reg_rdata_out;
	logic [1:0] status_out;
	logic sel_ok_out, blocked_out, trip_out, alarm_out, evt_valid_out, irq_out;
	logic [5:0] evt_mask_out;
	logic [39:0] evt_time_out;
	logic rd_seen = 1'b0;
	logic [31:0] rnd = 32'h0000_787B;
	logic [31:0] rd_q[$];
	logic [5:0] ev_q[$];
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	vjsel_top #(.TRIP_HOLD_CYC(20)) u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.cycle_start_in(cycle_start_in), .block_in(block_in), .ts_ms_in(ts_ms_in),
		.angle_in(angle_in), .volt_in(volt_in), .ch_avail_in(ch_avail_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .status_out(status_out),
		.sel_ok_out(sel_ok_out), .blocked_out(blocked_out), .trip_out(trip_out),
		.alarm_out(alarm_out), .evt_valid_out(evt_valid_out), .evt_mask_out(evt_mask_out),
		.evt_time_out(evt_time_out), .irq_out(irq_out));
	vjsel_blk_matrix u_blk (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_in(blk_req),
		.lag_in(4'h5), .block_out(block_in));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	task automatic cmp(input string n, input logic [39:0] e, input logic [39:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask : tick
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= w;
		reg_rd_in <= !w;
		if (!w)
			rd_q.push_back(d);
		tick(1);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
		tick(1);
	endtask : bus
	task automatic prog(input logic [15:0] a0, input int n);
		rnd = xs(rnd);
		angle_in[0] <= a0;
		angle_in[3] <= rnd[15:0];
		ts_ms_in <= ts_ms_in + 40'h5;
		cycle_start_in <= 1'b1;
		tick(1);
		cycle_start_in <= 1'b0;
		tick(n);
	endtask : prog
	initial
	begin
		forever #2.5 clk_sys_in = !clk_sys_in;
	end
	// Result watcher: read data one cycle after strobe, events as they pulse
	always @(posedge clk_sys_in)
	begin
		cyc <= cyc + 1;
		rd_seen <= reg_rd_in;
		if (rd_seen)
			cmp("rdata", rd_q.size() ? rd_q.pop_front() : 32'h0, reg_rdata_out);
		if (evt_valid_out)
		begin
			cmp("event", ev_q.size() ? ev_q.pop_front() : 6'h0, evt_mask_out);
			cmp("evt_time", ts_ms_in, evt_time_out);
		end
		if (cyc == 20000)
		begin
			err_total++;
			give_verdict();
		end
	end
	initial
	begin
		tick(20);
		rst_in <= 1'b0;
		tick(1);
		cmp("status", 2'h0, status_out);
		bus(0, 8'h00, 32'h0000_0070);
		bus(0, 8'h04, 32'h0000_251C);
		bus(0, 8'h08, 32'h0000_01F4);
		bus(0, 8'h10, 32'h0000_003F);
		bus(0, 8'hFC, 32'h0000_0000);
		bus(0, 8'h14, 32'h0000_0004);
		ch_avail_in <= 4'h6;
		tick(3);
		cmp("sel_ok", 1'b0, sel_ok_out);
		ch_avail_in <= 4'hF;
		$display("test reset done");
		ev_q = {ev_q, 6'h04, 6'h08};
		prog(16'h0258, 4);
		cmp("trip", 2'h3, {trip_out, status_out[1]});
		tick(150);
		cmp("trip_end", 1'b0, trip_out);
		bus(0, 8'h30, 32'h0000_0258);
		bus(0, 8'h40, 32'h0000_00C8);
		bus(0, 8'h28, 32'h0000_0001);
		bus(1, 8'h1C, 32'h0000_0004);
		tick(2);
		cmp("irq", 1'b1, irq_out);
		bus(1, 8'h18, 32'h0000_003F);
		tick(2);
		cmp("irq", 1'b0, irq_out);
		repeat (4) prog(16'h0258, 150);
		$display("test trip done");
		blk_req <= 1'b1;
		tick(20);
		ev_q = {ev_q, 6'h01, 6'h02};
		prog(16'h0000, 5);
		cmp("blocked", 3'h4, {blocked_out, trip_out, alarm_out});
		cmp("status", 2'h1, status_out);
		tick(150);
		bus(0, 8'h30, 32'hFFFF_FDA8);
		repeat (4) prog(16'h0000, 150);
		blk_req <= 1'b0;
		$display("test block done");
		bus(1, 8'h00, 32'h0000_0071);
		bus(1, 8'h08, 32'h0000_07D0);
		bus(1, 8'h0C, 32'h0000_012C);
		ev_q = {ev_q, 6'h10, 6'h20};
		prog(16'h0190, 5);
		cmp("alarm", 4'h7, {trip_out, alarm_out, status_out});
		tick(150);
		repeat (4) prog(16'h0190, 150);
		$display("test alarm done");
		bus(1, 8'h10, 32'h0000_0001);
		ev_q = {ev_q, 6'h01};
		volt_in[1] <= 16'h2328;
		prog(16'h0190, 150);
		cmp("uv", 3'h5, {blocked_out, status_out});
		volt_in[1] <= 16'h4A38;
		prog(16'h0190, 150);
		cmp("uv_end", 1'b0, blocked_out);
		bus(1, 8'h10, 32'h0000_003F);
		cmp("irq_masked", 1'b0, irq_out);
		$display("test undervoltage done");
		bus(0, 8'h2C, 32'h0000_0002);
		bus(0, 8'h24, 32'h0000_0001);
		bus(1, 8'h20, 32'h0000_0007);
		bus(0, 8'h28, 32'h0000_0000);
		bus(0, 8'h14, 32'h0000_0044);
		bus(1, 8'h50, 32'h0000_0000);
		bus(0, 8'h5C, 32'h0000_0004);
		bus(1, 8'h50, 32'h0000_0003);
		bus(0, 8'h5C, 32'h0000_0001);
		bus(0, 8'h60, 32'h0000_0258);
		bus(0, 8'h54, 32'h0000_0005);
		bus(1, 8'h50, 32'h0000_000C);
		bus(0, 8'h5C, 32'h0000_0000);
		// All monitored channels must step before alarm
		bus(1, 8'h00, 32'h0000_0171);
		prog(16'h0000, 150);
		cmp("all_mode", 3'h0, {alarm_out, status_out});
		rnd = xs(rnd);
		bus(1, 8'h0C, {16'h0, rnd[15:0]});
		bus(0, 8'h0C, {16'h0, rnd[15:0]});
		tick(2);
		cmp("pending", 0, ev_q.size() + rd_q.size());
		$display("test records done");
		give_verdict();
	end
endmodule : vjsel_top_tb
`default_nettype wire
